//--- rtl/wdt_timer_unit.sv
`default_nettype none
module wdt_timer_unit
#(
   parameter int unsigned INTERVAL0 = 131072,
   parameter int unsigned INTERVAL1 = 1048576,
   parameter int unsigned INTERVAL2 = 8388608,
   parameter int unsigned INTERVAL3 = 67108864
)
(
   input wire logic ref_clk,
   input wire logic rst,
   // high when the reset being applied is power-on or power-fail
   input wire logic powerReset,
   input wire logic timedAccessOk,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic sysResetReq,
   output logic wdogIrq,
   output logic irqOut
);
   import wdt_pkg::*;

   typedef struct packed
   {
      wdt_state_e state;
      logic [WDT_CNT_W-1:0] count;
      logic [9:0] grace;
      logic [3:0] hold;
      logic wdog_timeout_flag;
      logic wdog_reset_cause_flag;
      logic wdog_reset_arm;
      logic [7:0] clock_speed_control;
      logic wdogIen;
      logic global_irq_enable;
      logic [1:0] irqStat;
      logic [1:0] irqMask;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic sysRst;
      logic wIrq;
      logic irq;
   } wdt_s;

   wdt_s st_reg;
   wdt_s st_next;
   logic access;
   logic wr;
   logic prot;
   logic [1:0] sel;
   logic [WDT_CNT_W-1:0] limit;
   logic expire;
   logic restart;
   logic [1:0] events;

   ////////////////////////////////////////////////////////////////////////
   assign access = psel && penable && !st_reg.ready;
   assign wr = access && pwrite;
   assign prot = wr && timedAccessOk && (paddr == WDT_CTRL_OFS);
   assign restart = prot && pwdata[WDT_RESTART_BIT];
   assign sel = st_reg.clock_speed_control[WDT_SEL_LO_BIT+1:WDT_SEL_LO_BIT];

   always_comb
   begin
      unique case (sel)
         2'h0: limit = WDT_CNT_W'(INTERVAL0 - 1);
         2'h1: limit = WDT_CNT_W'(INTERVAL1 - 1);
         2'h2: limit = WDT_CNT_W'(INTERVAL2 - 1);
         2'h3: limit = WDT_CNT_W'(INTERVAL3 - 1);
      endcase
   end

   assign expire = (st_reg.count >= limit);

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_next = st_reg;
      events = 2'h0;
      st_next.sysRst = 1'b0;

      st_next.count = st_reg.count + 1'b1;
      if (expire)
      begin
         st_next.count = '0;
         st_next.wdog_timeout_flag = 1'b1;
         events[WDT_EV_TIMEOUT] = 1'b1;
      end

      unique case (st_reg.state)
         WDT_RUN:
         begin
            if (expire)
            begin
               st_next.state = WDT_GRACE;
               st_next.grace = '0;
            end
         end
         WDT_GRACE:
         begin
            st_next.grace = st_reg.grace + 1'b1;
            if (st_reg.grace == 10'(WDT_GRACE_CYCLES - 1))
            begin
               st_next.state = WDT_RUN;
               if (st_reg.wdog_reset_arm)
               begin
                  st_next.state = WDT_HOLD;
                  st_next.hold = '0;
                  st_next.sysRst = 1'b1;
                  st_next.wdog_reset_cause_flag = 1'b1;
                  events[WDT_EV_RESET] = 1'b1;
               end
            end
         end
         WDT_HOLD:
         begin
            st_next.hold = st_reg.hold + 1'b1;
            st_next.sysRst = (st_reg.hold != 4'(WDT_RST_HOLD_CYCLES - 1));
            if (!st_next.sysRst)
            begin
               st_next.state = WDT_RUN;
            end
            st_next.count = '0;
            st_next.wdog_timeout_flag = 1'b0;
         end
      endcase

      if (restart && st_reg.state != WDT_HOLD)
      begin
         st_next.count = '0;
         st_next.state = WDT_RUN;
      end

      // register access
      st_next.ready = access;
      st_next.slverr = 1'b0;
      st_next.rdata = '0;
      if (access)
      begin
         unique case (paddr)
            WDT_CTRL_OFS:
            begin
               st_next.rdata[WDT_FLAG_BIT] = st_reg.wdog_timeout_flag;
               st_next.rdata[WDT_CAUSE_BIT] = st_reg.wdog_reset_cause_flag;
               st_next.rdata[WDT_ARM_BIT] = st_reg.wdog_reset_arm;
               if (prot)
               begin
                  st_next.wdog_reset_arm = pwdata[WDT_ARM_BIT];
                  if (!pwdata[WDT_FLAG_BIT] && !events[WDT_EV_TIMEOUT])
                  begin
                     st_next.wdog_timeout_flag = 1'b0;
                  end
               end
               // cause flag is not protected; set wins over clear
               if (wr && !pwdata[WDT_CAUSE_BIT] && !events[WDT_EV_RESET])
               begin
                  st_next.wdog_reset_cause_flag = 1'b0;
               end
            end
            WDT_CLOCK_SPEED_CONTROL_OFS:
            begin
               st_next.rdata[7:0] = st_reg.clock_speed_control;
               if (wr)
               begin
                  st_next.clock_speed_control = pwdata[7:0];
               end
            end
            WDT_IRQEN_OFS:
            begin
               st_next.rdata[WDT_IEN_BIT] = st_reg.wdogIen;
               st_next.rdata[WDT_GIEN_BIT] = st_reg.global_irq_enable;
               if (wr)
               begin
                  st_next.wdogIen = pwdata[WDT_IEN_BIT];
                  st_next.global_irq_enable = pwdata[WDT_GIEN_BIT];
               end
            end
            WDT_IRQST_OFS:
            begin
               st_next.rdata[1:0] = st_reg.irqStat;
               if (wr)
               begin
                  st_next.irqStat = st_reg.irqStat & ~pwdata[1:0];
               end
            end
            WDT_IRQMSK_OFS:
            begin
               st_next.rdata[1:0] = st_reg.irqMask;
               if (wr)
               begin
                  st_next.irqMask = pwdata[1:0];
               end
            end
            default:
            begin
               st_next.slverr = 1'b1;
            end
         endcase
      end

      // sticky status, set wins over write-one-clear
      st_next.irqStat = st_next.irqStat | events;
      st_next.wIrq = st_next.wdog_timeout_flag && st_next.wdogIen
         && st_next.global_irq_enable;
      st_next.irq = |(st_next.irqStat & st_next.irqMask);
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         st_reg <= st_next;
         st_reg.state <= WDT_RUN;
         st_reg.count <= '0;
         st_reg.grace <= '0;
         st_reg.hold <= '0;
         st_reg.sysRst <= 1'b0;
         st_reg.wIrq <= 1'b0;
         st_reg.ready <= 1'b0;
         st_reg.slverr <= 1'b0;
         st_reg.rdata <= '0;
         st_reg.wdog_timeout_flag <= 1'b0;
         st_reg.clock_speed_control <= WDT_CLOCK_SPEED_CONTROL_RESET;
         st_reg.wdogIen <= 1'b0;
         st_reg.global_irq_enable <= 1'b0;
         st_reg.irqStat <= WDT_IRQ_RESET;
         st_reg.irqMask <= WDT_IRQ_RESET;
         st_reg.irq <= 1'b0;
         if (powerReset)
         begin
            st_reg.wdog_reset_arm <= 1'b0;
            st_reg.wdog_reset_cause_flag <= 1'b0;
         end
         else
         begin
            st_reg.wdog_reset_arm <= st_reg.wdog_reset_arm;
            st_reg.wdog_reset_cause_flag <= st_reg.wdog_reset_cause_flag;
         end
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign sysResetReq = st_reg.sysRst;
   assign wdogIrq = st_reg.wIrq;
   assign irqOut = st_reg.irq;
   assign prdata = st_reg.rdata;
   assign pready = st_reg.ready;
   assign pslverr = st_reg.slverr;
endmodule
`default_nettype wire

//--- rtl/wdt_pkg.sv
`default_nettype none
package wdt_pkg;
   localparam logic [11:0] WDT_CTRL_OFS = 12'h000;
   localparam logic [11:0] WDT_CLOCK_SPEED_CONTROL_OFS = 12'h004;
   localparam logic [11:0] WDT_IRQEN_OFS = 12'h008;
   localparam logic [11:0] WDT_IRQST_OFS = 12'h00c;
   localparam logic [11:0] WDT_IRQMSK_OFS = 12'h010;
   localparam int WDT_RESTART_BIT = 0;
   localparam int WDT_ARM_BIT = 1;
   localparam int WDT_CAUSE_BIT = 2;
   localparam int WDT_FLAG_BIT = 3;
   localparam int WDT_SEL_LO_BIT = 6;
   localparam int WDT_IEN_BIT = 4;
   localparam int WDT_GIEN_BIT = 7;
   localparam logic [1:0] WDT_SEL_RESET = 2'h0;
   localparam logic [7:0] WDT_CLOCK_SPEED_CONTROL_RESET = 8'h00;
   localparam logic [1:0] WDT_IRQ_RESET = 2'h0;
   // status bit 0: time-out event, bit 1: watchdog reset event
   localparam int WDT_EV_TIMEOUT = 0;
   localparam int WDT_EV_RESET = 1;
   localparam int WDT_GRACE_CYCLES = 512;
   localparam int WDT_CLKS_PER_MACHINE = 4;
   localparam int WDT_RST_HOLD_CYCLES = 2 * WDT_CLKS_PER_MACHINE;
   localparam int WDT_CNT_W = 26;
   typedef enum logic [2:0]
   {
      WDT_RUN = 3'b001,
      WDT_GRACE = 3'b010,
      WDT_HOLD = 3'b100
   } wdt_state_e;
endpackage
`default_nettype wire

//--- test/wdt_timer_unit_assertions.sv
`default_nettype none
module wdt_timer_unit_assertions
import wdt_pkg::*;
#(
   parameter int unsigned INTERVAL0 = 131072
)
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic powerReset,
   input wire logic timedAccessOk,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic sysResetReq,
   input wire logic wdogIrq,
   input wire logic irqOut
);
   wire logic req = psel && penable && !pready;
   wire logic kick = req && pwrite && paddr == WDT_CTRL_OFS && timedAccessOk;
   wire logic mapped = paddr inside {WDT_CTRL_OFS, WDT_CLOCK_SPEED_CONTROL_OFS, WDT_IRQEN_OFS,
      WDT_IRQST_OFS, WDT_IRQMSK_OFS};
   logic armSeen = 1'h0;
   logic [31:0] since = '0;
   // shadow of arm bit and of cycles since the last restart
   always_ff @(posedge ref_clk)
   begin
      if (rst && powerReset)
         armSeen <= 1'h0;
   else if (kick)
         armSeen <= pwdata[WDT_ARM_BIT];
      // a reset of either kind also restarts the count
      if (rst || sysResetReq || (kick && pwdata[WDT_RESTART_BIT]))
         since <= '0;
      else if (!since[31])
         since <= since + 32'h1;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_wait; req |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("pready late");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("pready long");
   property p_err; req |=> pslverr == !$past(mapped) && (!pslverr || prdata == 32'h0); endproperty
   a_err: assert property (p_err) else $error("slverr wrong");
   property p_rwt; req && !pwrite && paddr == WDT_CTRL_OFS |=> !prdata[0]; endproperty
   a_rwt: assert property (p_rwt) else $error("restart bit reads 1");
   property p_hold; $rose(sysResetReq) |-> sysResetReq [*8] ##1 !sysResetReq; endproperty
   a_hold: assert property (p_hold) else $error("reset width");
   // early reset would mean the grace window was skipped
   property p_grace;
      $rose(sysResetReq) |-> since >= INTERVAL0 + WDT_GRACE_CYCLES - 1;
   endproperty
   a_grace: assert property (p_grace) else $error("reset early");
   property p_armed; $rose(sysResetReq) |-> armSeen; endproperty
   a_armed: assert property (p_armed) else $error("reset unarmed");
   property p_clr; $fell(rst) |-> !sysResetReq && !wdogIrq && !irqOut && !pready; endproperty
   a_clr: assert property (p_clr) else $error("outputs after reset");
   c_rst: cover property ($rose(sysResetReq));
   c_irq: cover property ($rose(wdogIrq));
   c_err: cover property (pready && pslverr);
endmodule
bind wdt_timer_unit wdt_timer_unit_assertions #(.INTERVAL0(INTERVAL0)) chk_u (.*);
`default_nettype wire

//--- test/watchdog_timer_unit_tb_top.sv
`default_nettype none
module watchdog_timer_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import wdt_pkg::*;
   localparam int IV[4] = '{64, 128, 256, 512};
   logic ref_clk = 1'h0, rst = 1'h1, powerReset = 1'h1, timedAccessOk = 1'h0;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, sysResetReq, wdogIrq, irqOut;
   int fail_count = 0, checked = 0, n;
   int regM[5] = '{0, 0, 0, 0, 0};
   always #20 ref_clk = ~ref_clk;
   wdt_timer_unit #(.INTERVAL0(IV[0]), .INTERVAL1(IV[1]), .INTERVAL2(IV[2]),
      .INTERVAL3(IV[3])) dut_u (.*);
   ////////////////////////////////////////
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic acc);
      int k;
      k = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      timedAccessOk <= acc;
      @(posedge ref_clk);
      penable <= 1'h1;
      do
      begin
         @(posedge ref_clk);
         k++;
      end
      while (pready !== 1'h1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      timedAccessOk <= 1'h0;
      @(posedge ref_clk);
      chk("pready", 1, k < 20);
   endtask
   task automatic rdchk(int i);
      apb(1'h0, 12'(i * 4), 32'h0, 1'h0);
      chk("reg", regM[i], rd);
      chk("slverr", 0, err);
   endtask
   task automatic wr(int i, int d);
      apb(1'h1, 12'(i * 4), d, 1'h1);
      regM[i] = d;
   endtask
   task automatic wait_hi(ref logic s, input int lim);
      n = 0;
      while (s !== 1'h1 && n < lim)
      begin
         @(posedge ref_clk);
         n++;
      end
   endtask
   task automatic rst16(logic pw);
      rst <= 1'h1;
      powerReset <= pw;
      repeat (16) @(posedge ref_clk);
      rst <= 1'h0;
      powerReset <= 1'h0;
      @(posedge ref_clk);
   endtask
   task automatic results();
      $display("checked %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      void'($urandom(19164));
      rst16(1'h1);
      for (int i = 0; i < 5; i++) rdchk(i);
      apb(1'h1, 12'h014, 32'h0, 1'h1);
      chk("unmapped", 1, err);
      wr(1, $urandom & 32'hff);
      rdchk(1);
      // arm write without permission must not stick
      apb(1'h1, WDT_CTRL_OFS, 32'h2, 1'h0);
      rdchk(0);
      wr(2, 32'h90);
      for (int s = 0; s < 4; s++)
      begin
         wr(1, s << 6);
         apb(1'h1, WDT_CTRL_OFS, 32'h1, 1'h1);
         wait_hi(wdogIrq, 2000);
         chk("interval", 1, n > IV[s] - 6 && n < IV[s] + 4);
         regM[0] = 8;
         regM[3] = 1;
         rdchk(0);
         rdchk(3);
         chk("irq masked", 0, irqOut);
         wr(4, 1);
         chk("irq open", 1, irqOut);
         apb(1'h1, WDT_IRQST_OFS, 32'h1, 1'h0);
         chk("irq cleared", 0, irqOut);
         wr(4, 0);
      end
      wr(2, 32'h10);
      chk("no global", 0, wdogIrq);
      apb(1'h1, WDT_CTRL_OFS, 32'h0, 1'h1);
      wr(2, 32'h90);
      chk("flag cleared", 0, wdogIrq);
      wr(1, 0);
      apb(1'h1, WDT_CTRL_OFS, 32'h3, 1'h1);
      wait_hi(sysResetReq, 700);
      chk("reset delay", 1, n > IV[0] + 503 && n < IV[0] + 518);
      n = 0;
      while (sysResetReq === 1'h1 && n < 20)
      begin
         @(posedge ref_clk);
         n++;
      end
      chk("reset hold", WDT_RST_HOLD_CYCLES, n);
      regM[0] = 6;
      regM[3] = 3;
      rdchk(0);
      rdchk(3);
      // plain reset keeps arm and cause
      rst16(1'h0);
      regM = '{6, 0, 0, 0, 0};
      for (int i = 0; i < 5; i++) rdchk(i);
      wr(2, 32'h90);
      wait_hi(wdogIrq, 200);
      apb(1'h1, WDT_CTRL_OFS, 32'h3, 1'h1);
      wait_hi(sysResetReq, 520);
      chk("grace restart", 520, n);
      regM[0] = 32'ha;
      rdchk(0);
      rst16(1'h1);
      regM[0] = 0;
      rdchk(0);
      results();
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      results();
   end
endmodule
`default_nettype wire
